// >>> verilog/pvc_pkg.sv
/*
  Shared constants of the protocol VLAN classifier: register map,
  field positions, reset values and key limits.
  Assumes a 32-bit register port and at most 32 ingress ports.
*/
`default_nettype none

package pvc_pkg;

  ////////////////////////////////////////////////////////////////
  // Widths
  localparam int PVC_ADDR_W = 8;
  localparam int PVC_DATA_W = 32;
  localparam int PVC_ETYPE_W = 16;
  localparam int PVC_VID_W = 12;
  localparam int PVC_PRIO_W = 3;
  localparam int PVC_PORT_W = 5;
  localparam int PVC_NUM_ENT = 16;
  localparam int PVC_NUM_PORT = 28;

  ////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] PVC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PVC_OFF_INDEX = 8'h04;
  localparam logic [7:0] PVC_OFF_ENTA = 8'h08;
  localparam logic [7:0] PVC_OFF_ENTB = 8'h0C;
  localparam logic [7:0] PVC_OFF_CMD = 8'h10;
  localparam logic [7:0] PVC_OFF_STAT = 8'h14;

  ////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PVC_CTRL_DOT1Q = 0;
  localparam int PVC_ENTA_ETYPE_LSB = 0;
  localparam int PVC_ENTA_PORT_LSB = 16;
  localparam int PVC_ENTA_IPSEL = 30;
  localparam int PVC_ENTA_ACTIVE = 31;
  localparam int PVC_ENTB_VID_LSB = 0;
  localparam int PVC_ENTB_PRIO_LSB = 12;
  localparam int PVC_ENTB_MARK = 16;
  localparam int PVC_ENTB_VALID = 17;
  localparam int PVC_CMD_COMMIT = 0;
  localparam int PVC_CMD_LOAD = 1;
  localparam int PVC_CMD_DELETE = 2;
  localparam int PVC_CMD_SAVE = 3;
  localparam int PVC_STAT_OK = 0;
  localparam int PVC_STAT_ETYPE = 1;
  localparam int PVC_STAT_VID = 2;
  localparam int PVC_STAT_PORT = 3;
  localparam int PVC_STAT_CNT_LSB = 8;

  ////////////////////////////////////////////////////////////////
  // Reset values and keys
  localparam logic PVC_RST_DOT1Q = 1'b0;
  localparam logic [15:0] PVC_ETYPE_MIN = 16'h0600;
  localparam logic [15:0] PVC_ETYPE_IP = 16'h0800;

endpackage : pvc_pkg

`default_nettype wire

// >>> verilog/pvc_key_check.sv
/*
  Admission check of a staged protocol entry before it is written.
  Assumes the static VLAN table answers vid_known_i combinationally.
*/
`default_nettype none

module pvc_key_check
  import pvc_pkg::*;
(
  input wire logic [pvc_pkg::PVC_ETYPE_W-1:0] etype_i, // Key
  input wire logic vid_known_i, // VID in static table
  input wire logic port_member_i, // Port in static VLAN
  output logic bad_etype_o, // Key in refused range
  output logic bad_vid_o, // VID undefined
  output logic bad_port_o, // Port not a member
  output logic ok_o // Entry acceptable
);

  always_comb begin
    bad_etype_o = etype_i < PVC_ETYPE_MIN; // see RL7
    bad_vid_o = !vid_known_i; // see RL9
    bad_port_o = !port_member_i; // see RL6
    ok_o = !(bad_etype_o || bad_vid_o || bad_port_o);
  end

endmodule : pvc_key_check

`default_nettype wire

// >>> verilog/pvc_first_hit.sv
/*
  Picks the lowest-index set bit of a hit vector.
  Assumes a purely combinational use inside one clock cycle.
*/
`default_nettype none

module pvc_first_hit #(
  parameter int N = 16,
  parameter int W = 4
) (
  input wire logic [N-1:0] hit_i, // One bit per entry
  output logic found_o, // Any bit set
  output logic [W-1:0] idx_o // Lowest set index
);

  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hit_i[i]) begin
        found_o = 1'b1;
        idx_o = W'(i);
      end
    end
  end

endmodule : pvc_first_hit

`default_nettype wire

// >>> verilog/pvc_classifier.sv
/*
  Protocol VLAN classifier at switch ingress, with its entry table
  and register port.
  Assumes frame descriptors synchronous to clk_sys_i, the port's
  default VID on frm_vid_i for untagged frames, and a static VLAN
  table that answers vid_known_i for vid_chk_o in the same cycle.
*/
// The address map and strobed register access were left to the implementer.
// What this block does
// RL1: Matching untagged frame on port gets entry VLAN
// RL2: Tagged frames keep their VLAN, untagged classified
// RL3: Table used only in 802.1Q tagged mode
// RL4: Matching frame also gets entry priority
// RL5: Inactive entries stay stored but never match
// RL6: Entry port must be static VLAN member
// RL7: Ethernet types 0x0000-0x05ff refused as keys
// RL8: Key is Ethernet type; IP selects 0800
// RL9: Entry VID must exist in static table
// RL10: Indexed entries readable and rewritable by index
// RL11: Edits live in volatile flops; save separate
// RL12: Delete removes all marked entries at once
// RL13: Priority is three bits, 0 to 7
`default_nettype none

module pvc_classifier
  import pvc_pkg::*;
#(
  parameter int NUM_ENT = pvc_pkg::PVC_NUM_ENT,
  parameter int NUM_PORT = pvc_pkg::PVC_NUM_PORT
) (
  input wire logic clk_sys_i, // 250 MHz clock
  input wire logic nrst_i, // Async reset, low
  input wire logic [pvc_pkg::PVC_ADDR_W-1:0] reg_addr_i, // Register address
  input wire logic [pvc_pkg::PVC_DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic reg_we_i, // Write strobe
  input wire logic reg_re_i, // Read strobe
  output logic [pvc_pkg::PVC_DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic [NUM_PORT-1:0] port_member_i, // Static VLAN members
  output logic [pvc_pkg::PVC_VID_W-1:0] vid_chk_o, // VID to look up
  input wire logic vid_known_i, // VID exists
  output logic nv_save_o, // Save request pulse
  input wire logic frm_valid_i, // Frame descriptor valid
  input wire logic [pvc_pkg::PVC_PORT_W-1:0] frm_port_i, // Ingress port
  input wire logic frm_tagged_i, // Frame has VLAN tag
  input wire logic [pvc_pkg::PVC_ETYPE_W-1:0] frm_etype_i, // Ethernet type
  input wire logic [pvc_pkg::PVC_VID_W-1:0] frm_vid_i, // Tag or default VID
  input wire logic [pvc_pkg::PVC_PRIO_W-1:0] frm_prio_i, // Tag or default prio
  output logic cls_valid_o, // Result valid
  output logic cls_hit_o, // Protocol entry matched
  output logic [pvc_pkg::PVC_VID_W-1:0] cls_vid_o, // Resulting VID
  output logic [pvc_pkg::PVC_PRIO_W-1:0] cls_prio_o // Resulting priority
);

  localparam int IDX_W = (NUM_ENT > 1) ? $clog2(NUM_ENT) : 1;
  localparam int CNT_W = $clog2(NUM_ENT + 1);

  ////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic port_in(
    input logic [PVC_PORT_W-1:0] p,
    input logic [NUM_PORT-1:0] m
  );
    logic r;
    r = 1'b0;
    for (int k = 0; k < NUM_PORT; k++) begin
      if (PVC_PORT_W'(k) == p) begin
        r = m[k];
      end
    end
    return r;
  endfunction : port_in

  function automatic logic sel(
    input logic [PVC_ADDR_W-1:0] a,
    input logic [7:0] off
  );
    return a == off;
  endfunction : sel

  ////////////////////////////////////////////////////////////////
  // Storage

  logic dot1q_q;
  logic [IDX_W-1:0] idx_q;
  logic stg_act_q;
  logic stg_ip_q;
  logic stg_mark_q;
  logic [PVC_PORT_W-1:0] stg_port_q;
  logic [PVC_ETYPE_W-1:0] stg_etype_q;
  logic [PVC_VID_W-1:0] stg_vid_q;
  logic [PVC_PRIO_W-1:0] stg_prio_q;
  logic [NUM_ENT-1:0] ent_valid_q;
  logic [NUM_ENT-1:0] ent_act_q;
  logic [NUM_ENT-1:0] ent_mark_q;
  logic [NUM_ENT-1:0] ent_ip_q;
  logic [PVC_PORT_W-1:0] ent_port_q [NUM_ENT];
  logic [PVC_ETYPE_W-1:0] ent_etype_q [NUM_ENT];
  logic [PVC_VID_W-1:0] ent_vid_q [NUM_ENT];
  logic [PVC_PRIO_W-1:0] ent_prio_q [NUM_ENT];
  logic st_ok_q;
  logic st_etype_q;
  logic st_vid_q;
  logic st_port_q;
  logic nv_save_q;
  logic [PVC_DATA_W-1:0] rdata_q;
  logic cls_valid_q;
  logic cls_hit_q;
  logic [PVC_VID_W-1:0] cls_vid_q;
  logic [PVC_PRIO_W-1:0] cls_prio_q;

  ////////////////////////////////////////////////////////////////
  // Decode

  logic wr_ctrl;
  logic wr_idx;
  logic wr_enta;
  logic wr_entb;
  logic do_commit;
  logic do_load;
  logic do_delete;
  logic do_save;
  logic [PVC_ETYPE_W-1:0] stg_key;
  logic chk_etype;
  logic chk_vid;
  logic chk_port;
  logic chk_ok;

  assign wr_ctrl = reg_we_i && sel(reg_addr_i, PVC_OFF_CTRL);
  assign wr_idx = reg_we_i && sel(reg_addr_i, PVC_OFF_INDEX);
  assign wr_enta = reg_we_i && sel(reg_addr_i, PVC_OFF_ENTA);
  assign wr_entb = reg_we_i && sel(reg_addr_i, PVC_OFF_ENTB);
  assign do_commit = reg_we_i && sel(reg_addr_i, PVC_OFF_CMD) && reg_wdata_i[PVC_CMD_COMMIT];
  assign do_load = reg_we_i && sel(reg_addr_i, PVC_OFF_CMD) && reg_wdata_i[PVC_CMD_LOAD];
  assign do_delete = reg_we_i && sel(reg_addr_i, PVC_OFF_CMD) && reg_wdata_i[PVC_CMD_DELETE];
  assign do_save = reg_we_i && sel(reg_addr_i, PVC_OFF_CMD) && reg_wdata_i[PVC_CMD_SAVE];

  // IP selection overrides the typed key
  assign stg_key = stg_ip_q ? PVC_ETYPE_IP : stg_etype_q; // see RL8

  pvc_key_check u_check (
    .etype_i(stg_key),
    .vid_known_i(vid_known_i),
    .port_member_i(port_in(stg_port_q, port_member_i)),
    .bad_etype_o(chk_etype),
    .bad_vid_o(chk_vid),
    .bad_port_o(chk_port),
    .ok_o(chk_ok)
  );

  ////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dot1q_q <= PVC_RST_DOT1Q;
      idx_q <= '0;
    end else begin
      if (wr_ctrl) begin
        dot1q_q <= reg_wdata_i[PVC_CTRL_DOT1Q];
      end
      if (wr_idx) begin
        idx_q <= reg_wdata_i[IDX_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Staging entry: written by software or loaded by index

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stg_act_q <= 1'b0;
      stg_ip_q <= 1'b0;
      stg_mark_q <= 1'b0;
      stg_port_q <= '0;
      stg_etype_q <= '0;
      stg_vid_q <= '0;
      stg_prio_q <= '0;
    end else if (do_load) begin // see RL10
      stg_act_q <= ent_act_q[idx_q];
      stg_ip_q <= ent_ip_q[idx_q];
      stg_mark_q <= ent_mark_q[idx_q];
      stg_port_q <= ent_port_q[idx_q];
      stg_etype_q <= ent_etype_q[idx_q];
      stg_vid_q <= ent_vid_q[idx_q];
      stg_prio_q <= ent_prio_q[idx_q];
    end else begin
      if (wr_enta) begin
        stg_etype_q <= reg_wdata_i[PVC_ENTA_ETYPE_LSB +: PVC_ETYPE_W];
        stg_port_q <= reg_wdata_i[PVC_ENTA_PORT_LSB +: PVC_PORT_W];
        stg_ip_q <= reg_wdata_i[PVC_ENTA_IPSEL];
        stg_act_q <= reg_wdata_i[PVC_ENTA_ACTIVE];
      end
      if (wr_entb) begin
        stg_vid_q <= reg_wdata_i[PVC_ENTB_VID_LSB +: PVC_VID_W];
        stg_prio_q <= reg_wdata_i[PVC_ENTB_PRIO_LSB +: PVC_PRIO_W]; // see RL13
        stg_mark_q <= reg_wdata_i[PVC_ENTB_MARK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Entry table in run-time flops; lost at power down

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ent_valid_q <= '0;
      ent_act_q <= '0;
      ent_mark_q <= '0;
      ent_ip_q <= '0;
      for (int i = 0; i < NUM_ENT; i++) begin
        ent_port_q[i] <= '0;
        ent_etype_q[i] <= '0;
        ent_vid_q[i] <= '0;
        ent_prio_q[i] <= '0;
      end
    end else begin
      if (do_delete) begin
        ent_valid_q <= ent_valid_q & ~ent_mark_q; // see RL12
        ent_mark_q <= '0;
      end
      if (do_commit && chk_ok) begin // see RL11
        ent_valid_q[idx_q] <= 1'b1;
        ent_act_q[idx_q] <= stg_act_q; // see RL5
        ent_mark_q[idx_q] <= stg_mark_q;
        ent_ip_q[idx_q] <= stg_ip_q;
        ent_port_q[idx_q] <= stg_port_q;
        ent_etype_q[idx_q] <= stg_key;
        ent_vid_q[idx_q] <= stg_vid_q;
        ent_prio_q[idx_q] <= stg_prio_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Commit status and save request

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ok_q <= 1'b0;
      st_etype_q <= 1'b0;
      st_vid_q <= 1'b0;
      st_port_q <= 1'b0;
      nv_save_q <= 1'b0;
    end else begin
      nv_save_q <= do_save; // see RL11
      if (do_commit) begin
        st_ok_q <= chk_ok;
        st_etype_q <= chk_etype; // see RL7
        st_vid_q <= chk_vid; // see RL9
        st_port_q <= chk_port; // see RL6
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register read

  logic [CNT_W-1:0] used_cnt;
  logic [PVC_DATA_W-1:0] rd_d;

  always_comb begin
    used_cnt = '0;
    for (int i = 0; i < NUM_ENT; i++) begin
      used_cnt = used_cnt + CNT_W'(ent_valid_q[i]);
    end
  end

  always_comb begin
    rd_d = '0;
    unique case (reg_addr_i)
      PVC_OFF_CTRL: rd_d[PVC_CTRL_DOT1Q] = dot1q_q;
      PVC_OFF_INDEX: rd_d[IDX_W-1:0] = idx_q;
      PVC_OFF_ENTA: begin // see RL10
        rd_d[PVC_ENTA_ETYPE_LSB +: PVC_ETYPE_W] = stg_etype_q;
        rd_d[PVC_ENTA_PORT_LSB +: PVC_PORT_W] = stg_port_q;
        rd_d[PVC_ENTA_IPSEL] = stg_ip_q;
        rd_d[PVC_ENTA_ACTIVE] = stg_act_q;
      end
      PVC_OFF_ENTB: begin
        rd_d[PVC_ENTB_VID_LSB +: PVC_VID_W] = stg_vid_q;
        rd_d[PVC_ENTB_PRIO_LSB +: PVC_PRIO_W] = stg_prio_q;
        rd_d[PVC_ENTB_MARK] = stg_mark_q;
        rd_d[PVC_ENTB_VALID] = ent_valid_q[idx_q];
      end
      PVC_OFF_STAT: begin
        rd_d[PVC_STAT_OK] = st_ok_q;
        rd_d[PVC_STAT_ETYPE] = st_etype_q;
        rd_d[PVC_STAT_VID] = st_vid_q;
        rd_d[PVC_STAT_PORT] = st_port_q;
        rd_d[PVC_STAT_CNT_LSB +: CNT_W] = used_cnt;
      end
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_re_i ? rd_d : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Frame classification

  logic [NUM_ENT-1:0] hit;
  logic hit_any;
  logic [IDX_W-1:0] hit_idx;
  logic classify;

  // Only untagged frames in tagged VLAN mode from member ports
  assign classify = dot1q_q && !frm_tagged_i // see RL2, RL3
    && port_in(frm_port_i, port_member_i); // see RL6

  always_comb begin
    for (int i = 0; i < NUM_ENT; i++) begin
      hit[i] = classify && ent_valid_q[i] && ent_act_q[i] // see RL5
        && ent_port_q[i] == frm_port_i
        && ent_etype_q[i] == frm_etype_i; // see RL1, RL8
    end
  end

  pvc_first_hit #(
    .N(NUM_ENT),
    .W(IDX_W)
  ) u_pick (
    .hit_i(hit),
    .found_o(hit_any),
    .idx_o(hit_idx)
  );

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cls_valid_q <= 1'b0;
      cls_hit_q <= 1'b0;
      cls_vid_q <= '0;
      cls_prio_q <= '0;
    end else begin
      cls_valid_q <= frm_valid_i;
      if (frm_valid_i) begin
        cls_hit_q <= hit_any;
        if (hit_any) begin
          cls_vid_q <= ent_vid_q[hit_idx]; // see RL1
          cls_prio_q <= ent_prio_q[hit_idx]; // see RL4
        end else begin
          cls_vid_q <= frm_vid_i; // see RL2
          cls_prio_q <= frm_prio_i;
        end
      end else begin
        cls_hit_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o = rdata_q;
  assign vid_chk_o = stg_vid_q;
  assign nv_save_o = nv_save_q;
  assign cls_valid_o = cls_valid_q;
  assign cls_hit_o = cls_hit_q;
  assign cls_vid_o = cls_vid_q;
  assign cls_prio_o = cls_prio_q;

endmodule : pvc_classifier

`default_nettype wire

// >>> test/pvc_cls_properties.sv
/*
  Port-level checker of the protocol VLAN classifier.
  Assumes it is bound to pvc_classifier and sees only its ports.
*/
`default_nettype none

module pvc_cls_chk
  import pvc_pkg::*;
#(
  parameter int NUM_ENT = 16,
  parameter int NUM_PORT = 28
) (
  input wire logic clk_sys_i, // Clock
  input wire logic nrst_i, // Reset, low
  input wire logic [pvc_pkg::PVC_ADDR_W-1:0] reg_addr_i, // Address
  input wire logic [pvc_pkg::PVC_DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic reg_we_i, // Write strobe
  input wire logic reg_re_i, // Read strobe
  input wire logic [pvc_pkg::PVC_DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic [NUM_PORT-1:0] port_member_i, // Members
  input wire logic nv_save_o, // Save pulse
  input wire logic frm_valid_i, // Frame valid
  input wire logic [pvc_pkg::PVC_PORT_W-1:0] frm_port_i, // Port
  input wire logic frm_tagged_i, // Tagged
  input wire logic [pvc_pkg::PVC_ETYPE_W-1:0] frm_etype_i, // Type
  input wire logic [pvc_pkg::PVC_VID_W-1:0] frm_vid_i, // VID in
  input wire logic [pvc_pkg::PVC_PRIO_W-1:0] frm_prio_i, // Prio in
  input wire logic cls_valid_o, // Result valid
  input wire logic cls_hit_o, // Hit
  input wire logic [pvc_pkg::PVC_VID_W-1:0] cls_vid_o, // VID out
  input wire logic [pvc_pkg::PVC_PRIO_W-1:0] cls_prio_o // Prio out
);
  import pvc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero");
  chk_rdata_unmap: assert property (reg_re_i && reg_addr_i > PVC_OFF_STAT |=> reg_rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_cls_latency: assert property (frm_valid_i |=> cls_valid_o)
    else $error("result late");
  chk_cls_pulse: assert property (!frm_valid_i |=> !cls_valid_o && !cls_hit_o)
    else $error("stray result");
  chk_tag_keep: assert property (frm_valid_i && frm_tagged_i |=> !cls_hit_o && cls_vid_o == $past(frm_vid_i)
    && cls_prio_o == $past(frm_prio_i)) else $error("tagged frame changed");
  chk_miss_pass: assert property (cls_valid_o && !cls_hit_o |-> cls_vid_o == $past(frm_vid_i)
    && cls_prio_o == $past(frm_prio_i)) else $error("miss changed VID");
  chk_member_gate: assert property (frm_valid_i && !port_member_i[frm_port_i] |=> !cls_hit_o)
    else $error("non-member hit");
  chk_low_key: assert property (frm_valid_i && frm_etype_i < PVC_ETYPE_MIN |=> !cls_hit_o)
    else $error("low type hit");
  chk_result_hold: assert property (!frm_valid_i |=> $stable(cls_vid_o) && $stable(cls_prio_o))
    else $error("result not held");
  chk_save_req: assert property (reg_we_i && reg_addr_i == PVC_OFF_CMD && reg_wdata_i[PVC_CMD_SAVE] |=> nv_save_o)
    else $error("save pulse missing");
  chk_save_cause: assert property (nv_save_o |-> $past(reg_we_i) && $past(reg_addr_i) == PVC_OFF_CMD)
    else $error("save without command");
endmodule : pvc_cls_chk

bind pvc_classifier pvc_cls_chk #(.NUM_ENT(NUM_ENT), .NUM_PORT(NUM_PORT)) u_chk (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .port_member_i(port_member_i), .nv_save_o(nv_save_o),
  .frm_valid_i(frm_valid_i), .frm_port_i(frm_port_i), .frm_tagged_i(frm_tagged_i),
  .frm_etype_i(frm_etype_i), .frm_vid_i(frm_vid_i), .frm_prio_i(frm_prio_i), .cls_valid_o(cls_valid_o),
  .cls_hit_o(cls_hit_o), .cls_vid_o(cls_vid_o), .cls_prio_o(cls_prio_o));

`default_nettype wire

// >>> test/pvc_vlan_model.sv
/*
  Static VLAN table model: defined VIDs and port membership.
  Assumes the bench may drop ports to test the per-frame check.
*/
`default_nettype none

module pvc_vlan_model (
  input wire logic [11:0] vid_chk_o, // VID to look up
  input wire logic [27:0] drop_i, // Ports taken out
  output logic vid_known_i, // VID defined
  output logic [27:0] port_member_i // Member ports
);
  timeunit 1ns;
  timeprecision 1ps;
  // VLANs 5, 100 and 120 exist
  assign vid_known_i = (vid_chk_o == 12'h005) || (vid_chk_o == 12'h064) || (vid_chk_o == 12'h078);
  // Ports 1 to 7 are members
  assign port_member_i = 28'h000_00FE & ~drop_i;
endmodule : pvc_vlan_model

`default_nettype wire

// >>> test/tb_top.sv
/*
  Self-checking bench of the protocol VLAN classifier.
  Assumes the static VLAN model and the bound checker.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pvc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [27:0] port_member_i;
  logic [11:0] vid_chk_o;
  logic vid_known_i;
  logic nv_save_o;
  logic frm_valid_i = 1'b0;
  logic [4:0] frm_port_i = 5'h00;
  logic frm_tagged_i = 1'b0;
  logic [15:0] frm_etype_i = 16'h0000;
  logic [11:0] frm_vid_i = 12'h00A;
  logic [2:0] frm_prio_i = 3'h1;
  logic cls_valid_o;
  logic cls_hit_o;
  logic [11:0] cls_vid_o;
  logic [2:0] cls_prio_o;
  logic [27:0] drop = 28'h000_0000;
  logic [31:0] d;
  int errors = 0;
  int cmp_count = 0;
  int saves = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  // Save requests seen by the non-volatile store
  always @(posedge clk_sys_i) begin
    if (nv_save_o === 1'b1) begin
      saves++;
    end
  end

  pvc_classifier DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .port_member_i(port_member_i), .vid_chk_o(vid_chk_o), .vid_known_i(vid_known_i), .nv_save_o(nv_save_o),
    .frm_valid_i(frm_valid_i), .frm_port_i(frm_port_i), .frm_tagged_i(frm_tagged_i),
    .frm_etype_i(frm_etype_i), .frm_vid_i(frm_vid_i), .frm_prio_i(frm_prio_i), .cls_valid_o(cls_valid_o),
    .cls_hit_o(cls_hit_o), .cls_vid_o(cls_vid_o), .cls_prio_o(cls_prio_o));
  pvc_vlan_model u_vlan (.vid_chk_o(vid_chk_o), .drop_i(drop), .vid_known_i(vid_known_i),
    .port_member_i(port_member_i));

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_we_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1;
    v = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask : rd

  // Stage, commit to index, then read status
  task automatic commit(input logic [3:0] i, input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
    logic [31:0] st;
    wr(PVC_OFF_ENTA, a);
    wr(PVC_OFF_ENTB, b);
    wr(PVC_OFF_INDEX, {28'h000_0000, i});
    wr(PVC_OFF_CMD, 32'h0000_0001);
    rd(PVC_OFF_STAT, st);
    check(st, s);
  endtask : commit

  // Default VID 0x00A, priority 1 on every frame
  task automatic frm(input logic [4:0] p, input logic t, input logic [15:0] e, input logic h,
                     input logic [11:0] v, input logic [2:0] pr);
    frm_valid_i <= 1'b1;
    frm_port_i <= p;
    frm_tagged_i <= t;
    frm_etype_i <= e;
    @(posedge clk_sys_i);
    frm_valid_i <= 1'b0;
    #1;
    check({15'h0000, cls_valid_o, cls_hit_o, cls_vid_o, cls_prio_o}, {15'h0000, 1'b1, h, v, pr});
    @(posedge clk_sys_i);
  endtask : frm

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(PVC_OFF_CTRL, d);
    check(d, 32'h0000_0000);
    rd(PVC_OFF_STAT, d);
    check(d, 32'h0000_0000);
    rd(PVC_OFF_CMD, d);
    check(d, 32'h0000_0000);
    rd(8'h40, d);
    check(d, 32'h0000_0000);
    commit(4'h0, 32'h8001_0806, 32'h0000_3064, 32'h0000_0101);
    frm(5'd1, 1'b0, 16'h0806, 1'b0, 12'h00A, 3'd1);
    wr(PVC_OFF_CTRL, 32'h0000_0001);
    frm(5'd1, 1'b0, 16'h0806, 1'b1, 12'h064, 3'd3);
    frm(5'd1, 1'b1, 16'h0806, 1'b0, 12'h00A, 3'd1);
    frm(5'd2, 1'b0, 16'h0806, 1'b0, 12'h00A, 3'd1);
    frm(5'd2, 1'b0, 16'h05FF, 1'b0, 12'h00A, 3'd1);
    commit(4'h1, 32'h8001_05FF, 32'h0000_3064, 32'h0000_0102);
    commit(4'h1, 32'h8001_0806, 32'h0000_3777, 32'h0000_0104);
    commit(4'h1, 32'h8009_0806, 32'h0000_3064, 32'h0000_0108);
    commit(4'h1, 32'h8002_0600, 32'h0000_7078, 32'h0000_0201);
    frm(5'd2, 1'b0, 16'h0600, 1'b1, 12'h078, 3'd7);
    commit(4'h2, 32'hC003_1234, 32'h0000_0005, 32'h0000_0301);
    frm(5'd3, 1'b0, 16'h0800, 1'b1, 12'h005, 3'd0);
    commit(4'h3, 32'h0004_8137, 32'h0000_5064, 32'h0000_0401);
    frm(5'd4, 1'b0, 16'h8137, 1'b0, 12'h00A, 3'd1);
    wr(PVC_OFF_INDEX, 32'h0000_0002);
    wr(PVC_OFF_CMD, 32'h0000_0002);
    rd(PVC_OFF_ENTA, d);
    check({16'h0000, d[15:0]}, 32'h0000_0800);
    rd(PVC_OFF_ENTB, d);
    check({14'h0000, d[17:0]}, 32'h0002_0005);
    commit(4'h3, 32'h8004_8137, 32'h0000_5064, 32'h0000_0401);
    frm(5'd4, 1'b0, 16'h8137, 1'b1, 12'h064, 3'd5);
    drop <= 28'h000_0002;
    @(posedge clk_sys_i);
    frm(5'd1, 1'b0, 16'h0806, 1'b0, 12'h00A, 3'd1);
    drop <= 28'h000_0000;
    commit(4'h0, 32'h8001_0806, 32'h0001_3064, 32'h0000_0401);
    commit(4'h1, 32'h8002_0600, 32'h0001_7078, 32'h0000_0401);
    wr(PVC_OFF_CMD, 32'h0000_0004);
    rd(PVC_OFF_STAT, d);
    check({27'h000_0000, d[12:8]}, 32'h0000_0002);
    frm(5'd2, 1'b0, 16'h0600, 1'b0, 12'h00A, 3'd1);
    frm(5'd3, 1'b0, 16'h0800, 1'b1, 12'h005, 3'd0);
    wr(PVC_OFF_CMD, 32'h0000_0008);
    rd(PVC_OFF_STAT, d);
    check({27'h000_0000, d[12:8]}, 32'h0000_0002);
    check(saves, 32'h0000_0001);
    wr(PVC_OFF_CTRL, 32'h0000_0000);
    frm(5'd3, 1'b0, 16'h0800, 1'b0, 12'h00A, 3'd1);
    nrst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(PVC_OFF_STAT, d);
    check(d, 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
